// [hw/ssm_regs.svh]
// Offsets, field positions, reset values and counts of the spread modulator
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// First synthesizer profile and control registers
`define SSM_ADDR_SAMPLE0    8'hac
`define SSM_ADDR_SAMPLE_END 8'hb7
`define SSM_ADDR_STEP       8'hb8
`define SSM_ADDR_QCODE      8'hb9
`define SSM_ADDR_BASE       8'hba
`define SSM_ADDR_CTRL1      8'hbb
`define SSM_ADDR_STAT1      8'hbc
`define SSM_ADDR_POS1       8'hbd

// Fourth synthesizer registers, kept inside its own window
`define SSM_ADDR_FOURTH_LO  8'h4c
`define SSM_ADDR_FOURTH_HI  8'h85
`define SSM_ADDR_DIV4       8'h4c
`define SSM_ADDR_CTRL4      8'h4d
`define SSM_ADDR_FB4_LO     8'h4e
`define SSM_ADDR_FB4_HI     8'h4f
`define SSM_ADDR_STAT4      8'h50

// Field positions
`define SSM_CTRL1_DITHER    0
`define SSM_CTRL1_DOUBLE    1
`define SSM_CTRL4_ENABLE    0

// Reset values
`define SSM_RST_STEP        4'h0
`define SSM_RST_QCODE       3'h0
`define SSM_RST_BASE        6'h00
`define SSM_RST_DIV4        8'h00
`define SSM_RST_FB4         16'h0000
`define SSM_RST_LFSR        16'hace1

// Counts
`define SSM_NUM_SAMPLES     4'hc
`define SSM_STEP_EXTRA      5'h02
`define SSM_LFSR_TAPS       16'hb400

`endif

// [hw/ssm_pkg.sv]
// Types shared by the spread modulator modules
package ssm_pkg;

  // Quadrant of the modulation waveform
  typedef enum logic [1:0] {
    SSM_Q_RISE,
    SSM_Q_FALL,
    SSM_Q_NEG_FALL,
    SSM_Q_NEG_RISE
  } ssm_quad_t;

  typedef logic [3:0] ssm_sample_t;  // One delta sample
  typedef logic [3:0] ssm_index_t;   // Sample index 0..11

endpackage

// [hw/ssm_mem_if.sv]
// Port bundle between the modulator and its profile sample memory
interface ssm_mem_if;
  import ssm_pkg::*;
  logic        we;        // Write strobe
  ssm_index_t  waddr;     // Write index
  ssm_sample_t wdata;     // Write sample
  ssm_index_t  mod_addr;  // Modulator read index
  ssm_sample_t mod_data;  // Modulator read data, registered
  ssm_index_t  bus_addr;  // Register bus read index
  ssm_sample_t bus_data;  // Register bus read data, registered
  logic        re;        // Register bus read strobe

  modport mem (input we, input waddr, input wdata, input mod_addr, input bus_addr,
               input re, output mod_data, output bus_data);
  modport user (output we, output waddr, output wdata, output mod_addr, output bus_addr,
                output re, input mod_data, input bus_data);
endinterface

// [hw/ssm_profile_mem.sv]
// Twelve-entry delta sample store with two registered read ports
`include "ssm_regs.svh"
module ssm_profile_mem
  import ssm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  ssm_mem_if.mem   port
);

  ssm_sample_t store_ff [12];  // Sample entries

  // One write process per entry, cleared at reset
  for (genvar i = 0; i < 12; i++) begin : g_entry
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        store_ff[i] <= 4'h0;
      end else if (port.we && port.waddr == 4'(i)) begin
        store_ff[i] <= port.wdata;
      end
    end
  end

  // Indices past the last entry read zero
  wire mod_ok = port.mod_addr < `SSM_NUM_SAMPLES;
  wire bus_ok = port.bus_addr < `SSM_NUM_SAMPLES;

  // Registered reads; the bus copy only moves on a read strobe so it stands
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      port.mod_data <= 4'h0;
      port.bus_data <= 4'h0;
    end else begin
      port.mod_data <= mod_ok ? store_ff[port.mod_addr] : 4'h0;
      if (port.re) begin
        port.bus_data <= bus_ok ? store_ff[port.bus_addr] : 4'h0;
      end
    end
  end

endmodule

// [hw/ssm_lfsr.sv]
// Pseudo-random bit source for dithering the modulator input
`include "ssm_regs.svh"
module ssm_lfsr (
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic advance,
  output logic      rand_bit
);

  logic [15:0] lfsr_ff;      // Galois shift register
  logic [15:0] nxt_lfsr;     // Next state

  // Shift right, fold taps in when a one falls out
  assign nxt_lfsr = lfsr_ff[0] ? ((lfsr_ff >> 1) ^ `SSM_LFSR_TAPS) : (lfsr_ff >> 1);
  assign rand_bit = lfsr_ff[0];

  // Advances only on request so the pattern follows detector ticks
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lfsr_ff <= `SSM_RST_LFSR;
    end else if (advance) begin
      lfsr_ff <= nxt_lfsr;
    end
  end

endmodule

// [hw/ssm_top.sv]
// Spread-spectrum profile generator for the first and fourth synthesizers
//
// The address-and-strobe port and the address map are this design's own decisions.
`include "ssm_regs.svh"
module ssm_top
  import ssm_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PFD_REF,
  input  wire logic        IN_REF,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  output logic      [9:0]  FRAC_OFFSET,
  output logic             FIRST_SPREAD_ACTIVE,
  output logic             FOURTH_SPREAD_ACTIVE,
  output logic      [1:0]  FOURTH_MOD_PHASE,
  output logic      [15:0] FOURTH_FB_COUNT
);

  // Address is a profile sample slot
  function automatic logic is_sample_addr(input logic [7:0] a);
    is_sample_addr = (a >= `SSM_ADDR_SAMPLE0) && (a <= `SSM_ADDR_SAMPLE_END);
  endfunction

  // Sample index from a slot address
  function automatic ssm_index_t sample_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `SSM_ADDR_SAMPLE0;
    sample_index = d[3:0];
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers: bit 0 detector reference, bit 1 input reference
  // ------------------------------------------------------------------
  logic [1:0] sync1_ff;   // First stage, read only by second stage
  logic [1:0] sync2_ff;   // Second stage
  logic [1:0] prev_ff;    // Delayed copy for edge detect
  wire  [1:0] rise_tick;  // One-cycle pulse per rising edge

  // Both pins are far slower than the system clock; an edge closer
  // than two system cycles to the next would be missed
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      prev_ff  <= 2'h0;
    end else begin
      sync1_ff <= {IN_REF, PFD_REF};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign rise_tick = sync2_ff & ~prev_ff;
  wire pfd_tick = rise_tick[0];  // Detector reference cycle
  wire in_tick  = rise_tick[1];  // Input reference cycle

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  logic [3:0]  step_code_ff;  // Step period code
  logic [2:0]  qcode_ff;      // Quadrant sample code
  logic [5:0]  base_ff;       // Base offset
  logic        lsb_randomize_enable_ff;  // Dither enable
  logic        double_amplitude_ff;      // Amplitude doubling
  logic [7:0]  modulation_ref_divider_ff;       // Fourth synth divider
  logic        fourth_synth_spread_enable_ff;   // Fourth synth enable
  logic [15:0] modulation_feedback_count_ff;    // Fourth synth count

  // Write decodes
  wire wr_sample = REG_WR && is_sample_addr(REG_ADDR);
  wire wr_step   = REG_WR && (REG_ADDR == `SSM_ADDR_STEP);
  wire wr_qcode  = REG_WR && (REG_ADDR == `SSM_ADDR_QCODE);
  wire wr_base   = REG_WR && (REG_ADDR == `SSM_ADDR_BASE);
  wire wr_ctrl1  = REG_WR && (REG_ADDR == `SSM_ADDR_CTRL1);
  wire wr_div4   = REG_WR && (REG_ADDR == `SSM_ADDR_DIV4);
  wire wr_ctrl4  = REG_WR && (REG_ADDR == `SSM_ADDR_CTRL4);
  wire wr_fb4_lo = REG_WR && (REG_ADDR == `SSM_ADDR_FB4_LO);
  wire wr_fb4_hi = REG_WR && (REG_ADDR == `SSM_ADDR_FB4_HI);

  // First synthesizer settings
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      step_code_ff            <= `SSM_RST_STEP;
      qcode_ff                <= `SSM_RST_QCODE;
      base_ff                 <= `SSM_RST_BASE;
      lsb_randomize_enable_ff <= 1'b0;
      double_amplitude_ff     <= 1'b0;
    end else begin
      if (wr_step) step_code_ff <= REG_WDATA[3:0];
      if (wr_qcode) qcode_ff <= REG_WDATA[2:0];
      if (wr_base) base_ff <= REG_WDATA[5:0];
      if (wr_ctrl1) begin
        lsb_randomize_enable_ff <= REG_WDATA[`SSM_CTRL1_DITHER];
        double_amplitude_ff     <= REG_WDATA[`SSM_CTRL1_DOUBLE];
      end
    end
  end

  // Fourth synthesizer settings
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      modulation_ref_divider_ff     <= `SSM_RST_DIV4;
      fourth_synth_spread_enable_ff <= 1'b0;
      modulation_feedback_count_ff  <= `SSM_RST_FB4;
    end else begin
      if (wr_div4) modulation_ref_divider_ff <= REG_WDATA;
      if (wr_ctrl4) fourth_synth_spread_enable_ff <= REG_WDATA[`SSM_CTRL4_ENABLE];
      if (wr_fb4_lo) modulation_feedback_count_ff[7:0] <= REG_WDATA;
      if (wr_fb4_hi) modulation_feedback_count_ff[15:8] <= REG_WDATA;
    end
  end

  // ------------------------------------------------------------------
  // Profile sample memory
  // ------------------------------------------------------------------
  ssm_mem_if mem_bus ();

  ssm_profile_mem u_mem (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .port    (mem_bus)
  );

  // ------------------------------------------------------------------
  // First synthesizer step sequencer
  // ------------------------------------------------------------------
  ssm_quad_t  quad_ff;      // Current quadrant
  ssm_quad_t  nxt_quad;
  ssm_index_t idx_ff;       // Step within quadrant
  logic [4:0] step_cnt_ff;  // Detector cycles into current step
  logic [7:0] acc_ff;       // Accumulated delta magnitude
  logic [7:0] nxt_acc;

  wire first_en = (step_code_ff != 4'h0);
  wire [4:0] step_len = {1'b0, step_code_ff} + `SSM_STEP_EXTRA;
  wire [3:0] used_raw = {qcode_ff, 1'b0};
  // Codes past six would ask for more than twelve; later slots never exist
  wire [3:0] used_cnt = (used_raw > `SSM_NUM_SAMPLES) ? `SSM_NUM_SAMPLES : used_raw;
  wire [3:0] last_idx = used_cnt - 4'h1;

  // Step ends on the last detector cycle of its length
  wire step_done = first_en && pfd_tick && (step_cnt_ff >= step_len - 5'h01);
  wire quad_done = (used_cnt == 4'h0) || (idx_ff >= last_idx);

  // Second and fourth quadrants walk the same samples backwards
  wire backward = (quad_ff == SSM_Q_FALL) || (quad_ff == SSM_Q_NEG_RISE);
  wire negative = (quad_ff == SSM_Q_NEG_FALL) || (quad_ff == SSM_Q_NEG_RISE);
  wire [3:0] rev_idx = last_idx - idx_ff;

  // Read index leads the step boundary; a step is at least three
  // detector cycles, so the registered sample is always settled
  assign mem_bus.mod_addr = backward ? rev_idx : idx_ff;
  assign mem_bus.we       = wr_sample;
  assign mem_bus.waddr    = sample_index(REG_ADDR);
  assign mem_bus.wdata    = REG_WDATA[3:0];
  assign mem_bus.bus_addr = sample_index(REG_ADDR);
  assign mem_bus.re       = REG_RD;  // Later address or write moves nothing

  // Magnitude rises in first and third quadrant, falls in the others
  always_comb begin
    nxt_acc = acc_ff;
    if (used_cnt != 4'h0) begin
      if (backward) begin
        nxt_acc = acc_ff - {4'h0, mem_bus.mod_data};
      end else begin
        nxt_acc = acc_ff + {4'h0, mem_bus.mod_data};
      end
    end
  end

  // Quadrant order around one period
  always_comb begin
    case (quad_ff)
      SSM_Q_RISE:     nxt_quad = SSM_Q_FALL;
      SSM_Q_FALL:     nxt_quad = SSM_Q_NEG_FALL;
      SSM_Q_NEG_FALL: nxt_quad = SSM_Q_NEG_RISE;
      SSM_Q_NEG_RISE: nxt_quad = SSM_Q_RISE;
      default:        nxt_quad = SSM_Q_RISE;
    endcase
  end

  // Sequencer state; disabled spreading parks at the first rising step with zero magnitude
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      step_cnt_ff <= 5'h00;
      idx_ff      <= 4'h0;
      quad_ff     <= SSM_Q_RISE;
      acc_ff      <= 8'h00;
    end else if (!first_en) begin
      step_cnt_ff <= 5'h00;
      idx_ff      <= 4'h0;
      quad_ff     <= SSM_Q_RISE;
      acc_ff      <= 8'h00;
    end else if (step_done) begin
      step_cnt_ff <= 5'h00;
      acc_ff      <= nxt_acc;
      idx_ff      <= quad_done ? 4'h0 : idx_ff + 4'h1;
      if (quad_done) quad_ff <= nxt_quad;
    end else if (pfd_tick) begin
      step_cnt_ff <= step_cnt_ff + 5'h01;
    end
  end

  // ------------------------------------------------------------------
  // Offset value fed to the feedback divider
  // ------------------------------------------------------------------
  logic rand_bit;  // Dither bit

  ssm_lfsr u_lfsr (
    .SYS_CLK  (SYS_CLK),
    .RST_N    (RST_N),
    .advance  (pfd_tick),
    .rand_bit (rand_bit)
  );

  // Doubling widens the magnitude before the sign is applied
  wire [9:0] mag = double_amplitude_ff ? {1'b0, acc_ff, 1'b0} : {2'b00, acc_ff};
  wire [9:0] signed_mag = negative ? (10'h000 - mag) : mag;
  wire [9:0] raw_value = {4'h0, base_ff} + signed_mag;
  // Only the LSB is touched, so dither adds at most one count of noise
  wire [9:0] lsb_randomize_enable_value = lsb_randomize_enable_ff ? {raw_value[9:1], rand_bit}
                                                  : raw_value;

  // Registered outputs of the first synthesizer
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FRAC_OFFSET         <= 10'h000;
      FIRST_SPREAD_ACTIVE <= 1'b0;
    end else begin
      FRAC_OFFSET         <= first_en ? lsb_randomize_enable_value : 10'h000;
      FIRST_SPREAD_ACTIVE <= first_en;
    end
  end

  // ------------------------------------------------------------------
  // Fourth synthesizer modulation timing
  // ------------------------------------------------------------------
  logic [7:0] div_cnt_ff;  // Input cycles into current phase
  logic [1:0] phase_ff;    // Quarter of the modulation period

  // A zero divider would wrap to 256 input ticks per phase, so it counts as off
  wire active4 = fourth_synth_spread_enable_ff
               && (modulation_ref_divider_ff != 8'h00);
  wire phase_done = in_tick && (div_cnt_ff >= modulation_ref_divider_ff - 8'h01);

  // Four phases of divider length make one modulation period
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_ff <= 8'h00;
      phase_ff   <= 2'h0;
    end else if (!active4) begin
      div_cnt_ff <= 8'h00;
      phase_ff   <= 2'h0;
    end else if (phase_done) begin
      div_cnt_ff <= 8'h00;
      phase_ff   <= phase_ff + 2'h1;
    end else if (in_tick) begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end

  // Registered outputs of the fourth synthesizer
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FOURTH_SPREAD_ACTIVE <= 1'b0;
      FOURTH_MOD_PHASE     <= 2'h0;
      FOURTH_FB_COUNT      <= 16'h0000;
    end else begin
      FOURTH_SPREAD_ACTIVE <= active4;
      FOURTH_MOD_PHASE     <= active4 ? phase_ff : 2'h0;
      FOURTH_FB_COUNT      <= active4 ? modulation_feedback_count_ff : 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // Register read path
  // ------------------------------------------------------------------
  logic [7:0] rdata_ff;      // Captured non-sample read data
  logic       rd_sample_ff;  // Last read hit a sample slot
  logic [7:0] nxt_rdata;

  // Read mux; unmapped addresses and reserved bits answer zero
  always_comb begin
    case (REG_ADDR)
      `SSM_ADDR_STEP:   nxt_rdata = {4'h0, step_code_ff};
      `SSM_ADDR_QCODE:  nxt_rdata = {5'h00, qcode_ff};
      `SSM_ADDR_BASE:   nxt_rdata = {2'h0, base_ff};
      `SSM_ADDR_CTRL1:  nxt_rdata = {6'h00, double_amplitude_ff, lsb_randomize_enable_ff};
      `SSM_ADDR_STAT1:  nxt_rdata = {5'h00, quad_ff, first_en};
      `SSM_ADDR_POS1:   nxt_rdata = {4'h0, idx_ff};
      `SSM_ADDR_DIV4:   nxt_rdata = modulation_ref_divider_ff;
      `SSM_ADDR_CTRL4:  nxt_rdata = {7'h00, fourth_synth_spread_enable_ff};
      `SSM_ADDR_FB4_LO: nxt_rdata = modulation_feedback_count_ff[7:0];
      `SSM_ADDR_FB4_HI: nxt_rdata = modulation_feedback_count_ff[15:8];
      `SSM_ADDR_STAT4:  nxt_rdata = {5'h00, phase_ff, active4};
      default:          nxt_rdata = 8'h00;
    endcase
  end

  // Data holds until the next read strobe
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff     <= 8'h00;
      rd_sample_ff <= 1'b0;
    end else if (REG_RD) begin
      rdata_ff     <= nxt_rdata;
      rd_sample_ff <= is_sample_addr(REG_ADDR);
    end
  end

  // Sample reads come from the memory's own read register
  assign REG_RDATA = rd_sample_ff ? {4'h0, mem_bus.bus_data} : rdata_ff;

endmodule

// [tb/ssm_pll_model.sv]
// Far-side pin model: the synthesizer's detector and input reference clocks
module ssm_pll_model #(
  parameter int HALF = 5  // Half period in cycles; phases well above the 2-cycle minimum
) (
  input  wire logic SYS_CLK,
  input  wire logic pfd_en,     // Detector reference runs
  input  wire logic in_en,      // Input reference runs
  output logic      PFD_REF,    // Detector reference pin
  output logic      IN_REF,     // Input reference pin
  output int        pfd_ticks,  // Detector rises since enable
  output int        in_ticks    // Input rises since enable
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt = 0;  // Half-period counter shared by both pins

  initial begin
    PFD_REF   = 1'b0;
    IN_REF    = 1'b0;
    pfd_ticks = 0;
    in_ticks  = 0;
  end

  // Pins stand low while stopped; a stray edge there would shift every step
  always @(posedge SYS_CLK) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      PFD_REF <= pfd_en & ~PFD_REF;
      IN_REF  <= in_en & ~IN_REF;
      if (pfd_en && !PFD_REF) pfd_ticks <= pfd_ticks + 1;
      if (in_en && !IN_REF) in_ticks <= in_ticks + 1;
    end
    if (!pfd_en) pfd_ticks <= 0;
    if (!in_en) in_ticks <= 0;
  end
endmodule

// [tb/ssm_chk.sv]
// Port-level assertions for the spread modulator
module ssm_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        PFD_REF,
  input wire logic        IN_REF,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [9:0]  FRAC_OFFSET,
  input wire logic        FIRST_SPREAD_ACTIVE,
  input wire logic        FOURTH_SPREAD_ACTIVE,
  input wire logic [1:0]  FOURTH_MOD_PHASE,
  input wire logic [15:0] FOURTH_FB_COUNT
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Upper offset bits only move on steps, several cycles apart
  sequence s_off_hold;
    $stable(FRAC_OFFSET[9:1])[*3];
  endsequence
  // Phase holds unless the fourth spread drops
  sequence s_phase_hold;
    ($stable(FOURTH_MOD_PHASE) || !FOURTH_SPREAD_ACTIVE)[*3];
  endsequence
  // A write in one of the three cycles before
  sequence s_recent_wr;
    $past(REG_WR) || $past(REG_WR, 2) || $past(REG_WR, 3);
  endsequence

  a_off_idle_zero: assert property (
    !FIRST_SPREAD_ACTIVE && !$past(FIRST_SPREAD_ACTIVE) |-> FRAC_OFFSET == 10'h000)
    else $error("offset not zero while first spread off");
  a_off_step_pace: assert property (
    $changed(FRAC_OFFSET[9:1]) |=> s_off_hold)
    else $error("offset moved twice within a step");
  a_phase_pace: assert property (
    $changed(FOURTH_MOD_PHASE) && FOURTH_SPREAD_ACTIVE |=> s_phase_hold)
    else $error("phase moved faster than input ticks");
  a_phase_order: assert property (
    FOURTH_SPREAD_ACTIVE && $past(FOURTH_SPREAD_ACTIVE) && $changed(FOURTH_MOD_PHASE)
    |-> FOURTH_MOD_PHASE == $past(FOURTH_MOD_PHASE) + 2'h1)
    else $error("phase skipped a quarter");
  a_fourth_idle: assert property (
    !FOURTH_SPREAD_ACTIVE && !$past(FOURTH_SPREAD_ACTIVE)
    |-> FOURTH_MOD_PHASE == 2'h0 && FOURTH_FB_COUNT == 16'h0000)
    else $error("fourth outputs live while disabled");
  a_fb_steady: assert property (
    FOURTH_SPREAD_ACTIVE && $past(FOURTH_SPREAD_ACTIVE) && !$past(REG_WR)
    && !$past(REG_WR, 2) && !$past(REG_WR, 3)
    |-> $stable(FOURTH_FB_COUNT))
    else $error("feedback count moved without a write");
  a_rdata_hold: assert property (
    !$past(REG_RD) |-> $stable(REG_RDATA))
    else $error("read data moved without a read");
  a_first_cause: assert property (
    $rose(FIRST_SPREAD_ACTIVE) |-> s_recent_wr)
    else $error("first spread started without a write");
  a_fourth_cause: assert property (
    $rose(FOURTH_SPREAD_ACTIVE) |-> s_recent_wr)
    else $error("fourth spread started without a write");
endmodule

// [tb/testbench.sv]
// Self-checking bench: register bus, first and fourth synthesizer spreading
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;     // 250 MHz
  logic        rst_n = 1'b0;       // Async reset, active low
  logic [7:0]  reg_addr = 8'h00;   // Bus address
  logic [7:0]  reg_wdata = 8'h00;  // Bus write data
  logic        reg_wr = 1'b0;      // Write strobe
  logic        reg_rd = 1'b0;      // Read strobe
  logic        pfd_en = 1'b0;      // Detector pin runs
  logic        in_en = 1'b0;       // Input pin runs
  logic        pfd_ref;            // Detector pin
  logic        in_ref;             // Input pin
  logic [7:0]  reg_rdata;          // Bus read data
  logic [9:0]  frac_offset;        // Offset to the divider
  logic        first_act;          // First spread running
  logic        fourth_act;         // Fourth spread running
  logic [1:0]  fourth_phase;       // Fourth modulation quarter
  logic [15:0] fourth_fb;          // Fourth feedback count
  logic [7:0]  rd_val;             // Last read result
  int          pfd_ticks;          // Detector rises given
  int          in_ticks;           // Input rises given
  int          miscompares = 0;    // Failed checks
  int          num_checks = 0;     // All checks
  int          seed = 32'h27e6;    // Fixed random seed
  int          sd[12];             // Model: delta samples
  int          base, code, qc, dbl; // Model: shape settings

  always #2 sys_clk = ~sys_clk;

  ssm_top i_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .PFD_REF(pfd_ref), .IN_REF(in_ref),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FRAC_OFFSET(frac_offset), .FIRST_SPREAD_ACTIVE(first_act),
    .FOURTH_SPREAD_ACTIVE(fourth_act), .FOURTH_MOD_PHASE(fourth_phase),
    .FOURTH_FB_COUNT(fourth_fb));

  ssm_pll_model i_pll (
    .SYS_CLK(sys_clk), .pfd_en(pfd_en), .in_en(in_en), .PFD_REF(pfd_ref),
    .IN_REF(in_ref), .pfd_ticks(pfd_ticks), .in_ticks(in_ticks));

  // One comparison, counted
  task automatic chk(input logic [15:0] got, input int exp);
    num_checks++;
    if (got !== exp[15:0]) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp[15:0]);
    end
  endtask

  // Write strobe stays up; the next read or idle lowers it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
  endtask

  // Data is taken at the edge closing the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    rd_val = reg_rdata;
  endtask

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Offset after t detector ticks; second and fourth quarters walk the samples back
  function automatic int exp_off(input int t);
    int n, s, j, k, p;
    n = (2 * qc > 12) ? 12 : 2 * qc;
    s = (t / (code + 2)) % (4 * n);
    j = s % n;
    k = ((s / n) % 2) ? n - j : j;
    p = 0;
    for (int i = 0; i < k; i++) p += sd[i];
    p = dbl ? 2 * p : p;
    return (s / n >= 2) ? base - p : base + p;
  endfunction

  // Program a shape, follow it tick by tick, then switch it off
  task automatic run_first(input int c, input int q, input int d, input int di, input int nt);
    int ones;
    ones = 0;
    code = c;
    qc = q;
    dbl = d;
    base = 1 + ($random(seed) & 15);
    wr(8'hba, 8'(base));
    for (int i = 0; i < 12; i++) begin
      sd[i] = $random(seed) & 3;
      wr(8'hac + 8'(i), 8'(sd[i]));
    end
    wr(8'hbb, 8'(2 * d + di));
    wr(8'hb9, 8'(q));
    wr(8'hb8, 8'(c));
    idle();
    pfd_en <= 1'b1;
    repeat (nt) begin
      @(posedge pfd_ref);
      #1;
      if (frac_offset[0] === 1'b1) ones++;
      if (di) chk(16'(frac_offset[9:1]), (exp_off(pfd_ticks - 1) >>> 1) & 32'h1ff);
      else chk(16'(frac_offset), exp_off(pfd_ticks - 1) & 32'h3ff);
    end
    if (di) chk(16'(ones > 0 && ones < nt), 1);
    rd(8'hbc);
    chk(16'(rd_val[0]), 1);
    chk(16'(first_act), 1);
    pfd_en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    wr(8'hb8, 8'h00);
    idle();
    repeat (3) @(posedge sys_clk);
    chk({5'h00, first_act, frac_offset}, 0);
    $display("first spread test code %0d done", c);
  endtask

  // Fourth synthesizer with a given divider; zero divider must stay idle
  task automatic run_fourth(input int dv, input int nt);
    int fb;
    fb = $random(seed) & 32'hffff;
    wr(8'h4c, 8'(dv));
    wr(8'h4e, fb[7:0]);
    wr(8'h4f, fb[15:8]);
    wr(8'h4d, 8'h01);
    idle();
    in_en <= 1'b1;
    repeat (nt) begin
      @(posedge in_ref);
      #1;
      chk(16'(fourth_act), dv != 0);
      chk(16'(fourth_phase), dv ? ((in_ticks - 1) / dv) % 4 : 0);
      chk(fourth_fb, dv ? fb : 0);
    end
    in_en <= 1'b0;
    wr(8'h4d, 8'h00);
    idle();
    repeat (3) @(posedge sys_clk);
    chk(fourth_fb | 16'(fourth_phase) | 16'(fourth_act), 0);
    $display("fourth spread test divider %0d done", dv);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0] rst_regs[11];
    logic [7:0] acc[6][3];
    rst_regs = '{8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h00};
    acc = '{'{8'hac, 8'hf5, 8'h05}, '{8'hb9, 8'hff, 8'h07}, '{8'hbb, 8'hff, 8'h03},
            '{8'h4c, 8'ha5, 8'ha5}, '{8'h4f, 8'h3c, 8'h3c}, '{8'hbc, 8'hff, 8'h00}};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (rst_regs[i]) begin
      rd(rst_regs[i]);
      chk(16'(rd_val), 0);
    end
    foreach (acc[i]) begin
      wr(acc[i][0], acc[i][1]);
      rd(acc[i][0]);
      chk(16'(rd_val), 32'(acc[i][2]));
    end
    $display("register test done");
    run_first(5, 1, 0, 0, 60);
    run_first(14, 6, 1, 0, 200);
    run_first(6, 7, 0, 1, 150);
    run_fourth(1, 12);
    run_fourth(3, 30);
    run_fourth(0, 8);
    finish_test();
  end

  // Watchdog well past the expected run
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule

bind ssm_top ssm_chk i_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PFD_REF(PFD_REF), .IN_REF(IN_REF),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .FRAC_OFFSET(FRAC_OFFSET),
  .FIRST_SPREAD_ACTIVE(FIRST_SPREAD_ACTIVE), .FOURTH_SPREAD_ACTIVE(FOURTH_SPREAD_ACTIVE),
  .FOURTH_MOD_PHASE(FOURTH_MOD_PHASE), .FOURTH_FB_COUNT(FOURTH_FB_COUNT));
